// >>> src/vfp_consts.vh
// constants for the vlan tagged frame field parser
`ifndef VFP_CONSTS_VH
`define VFP_CONSTS_VH

// ==========================================================
// record byte offsets
`define VFP_OFS_TPID_HI     16'h0024
`define VFP_OFS_TPID_LO     16'h0025
`define VFP_OFS_TCI_HI      16'h0026
`define VFP_OFS_TCI_LO      16'h0027
`define VFP_OFS_ETYPE_TAG   16'h0028
`define VFP_OFS_PAYLD_TAG   16'h002A
`define VFP_OFS_PAYLD_UNTAG 16'h0026
`define VFP_FCS_TRAIL       16'h0005

// ==========================================================
// field values
`define VFP_TPID_CTAG       16'h8100
`define VFP_ET_IPV4         16'h0800
`define VFP_ET_IPV6         16'h08DD
`define VFP_ET_AVTP         16'h22F0
`define VFP_VID_NULL        12'h000
`define VFP_VID_DEFAULT     12'h001
`define VFP_PCP_DEFAULT     3'h0
`define VFP_PAYLD_MIN       16'h002E
`define VFP_PAYLD_MAX       16'h05DC

// ==========================================================
// tag control field positions
`define VFP_TCI_PCP_HI      15
`define VFP_TCI_PCP_LO      13
`define VFP_TCI_DEI         12
`define VFP_TCI_VID_HI      11
`define VFP_TCI_VID_LO      0

// ==========================================================
// protocol class codes
`define VFP_PROTO_OTHER     2'h0
`define VFP_PROTO_IPV4      2'h1
`define VFP_PROTO_IPV6      2'h2
`define VFP_PROTO_AVTP      2'h3

// ==========================================================
// fifo shape
`define VFP_FIFO_WIDTH      9
`define VFP_FIFO_DEPTH      4
`define VFP_FIFO_AW         2

`endif

// >>> src/vfp_fifo.v
// small valid/ready fifo carrying stream bytes
`timescale 1ns/1ps

module vfp_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             i_mclk,
	input  wire             i_rst,
	input  wire             i_in_valid,
	output wire             o_in_ready,
	input  wire [WIDTH-1:0] i_in_data,
	output wire             o_out_valid,
	input  wire             i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);

	// ==========================================================
	// storage and pointers
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;

	assign o_in_ready  = (count != DEPTH[AW:0]);
	assign o_out_valid = (count != {(AW+1){1'b0}});
	assign o_out_data  = mem[rd_ptr];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	always @(posedge i_mclk) begin
		if (push)
			mem[wr_ptr] <= i_in_data;
	end

	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			if (push & ~pop)
				count <= count + 1'b1;
			else if (pop & ~push)
				count <= count - 1'b1;
		end
	end

endmodule

// >>> src/vfp_parser.v
// vlan tagged frame record field parser, stream in, fields and bytes out
`timescale 1ns/1ps
`include "vfp_consts.vh"

module vfp_parser (
	input  wire        i_mclk,
	input  wire        i_rst,
	input  wire        i_in_valid,
	output wire        o_in_ready,
	input  wire [7:0]  i_in_data,
	input  wire        i_in_last,
	input  wire [15:0] i_rec_len,
	output wire        o_out_valid,
	input  wire        i_out_ready,
	output wire [7:0]  o_out_data,
	output wire        o_out_last,
	output wire        o_out_payload,
	output reg         o_hdr_valid,
	output reg         o_tagged,
	output reg         o_prio_tag,
	output reg  [2:0]  o_pcp,
	output reg         o_dei,
	output reg  [11:0] o_vid,
	output reg  [15:0] o_ethertype,
	output reg  [1:0]  o_proto,
	output reg  [15:0] o_payload_len,
	output reg         o_len_short,
	output reg         o_len_long,
	output reg         o_frame_done
);

	// ==========================================================
	// states
	localparam ST_HDR  = 3'b001;
	localparam ST_BODY = 3'b010;
	localparam ST_SKIP = 3'b100;

	reg  [2:0]  state;
	reg  [2:0]  next_state;
	reg  [15:0] pos;
	reg  [15:0] tpid;
	reg  [15:0] tci;
	reg  [15:0] etype_u;
	reg  [15:0] etype_t;
	reg         is_tag;
	reg  [15:0] pl_end;
	reg  [15:0] len_q;
	wire        take;
	wire        fifo_ready;
	wire [8:0]  fifo_out;
	wire [15:0] pl_start;
	wire [15:0] et_sel;
	wire [11:0] vid_raw;
	wire        in_payload;

	// input bytes stall whenever the fifo is full, so back-pressure reaches the source
	assign o_in_ready = fifo_ready;
	assign take       = i_in_valid & fifo_ready;

	// ==========================================================
	// byte position and header capture
	// the record length is latched at the first byte so a mid-frame change cannot move the payload end
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			pos     <= 16'h0000;
			tpid    <= 16'h0000;
			tci     <= 16'h0000;
			etype_t <= 16'h0000;
			len_q   <= 16'h0000;
			state   <= ST_HDR;
		end else begin
			state <= next_state;
			if (take) begin
				pos <= i_in_last ? 16'h0000 : pos + 16'h0001;
				if (pos == 16'h0000)
					len_q <= i_rec_len;
				case (pos)
					`VFP_OFS_TPID_HI: tpid[15:8]    <= i_in_data;
					`VFP_OFS_TPID_LO: tpid[7:0]     <= i_in_data;
					`VFP_OFS_TCI_HI:  tci[15:8]     <= i_in_data;
					`VFP_OFS_TCI_LO:  tci[7:0]      <= i_in_data;
					`VFP_OFS_ETYPE_TAG: etype_t[15:8] <= i_in_data;
					`VFP_OFS_ETYPE_TAG + 16'h0001: etype_t[7:0] <= i_in_data;
					default: ;
				endcase
			end
		end
	end

	// untagged ethertype shares bytes 36 to 37 with the tag identifier
	always @* begin
		etype_u = tpid;
		is_tag  = (tpid == `VFP_TPID_CTAG);
	end

	// ==========================================================
	// state walk: header, then body until the last byte; skip is never entered
	always @* begin
		next_state = state;
		case (state)
			ST_HDR: begin
				if (take & i_in_last)
					next_state = ST_HDR;
				else if (take & (pos == `VFP_OFS_PAYLD_TAG - 16'h0001))
					next_state = ST_BODY;
			end
			ST_BODY: begin
				if (take & i_in_last)
					next_state = ST_HDR;
			end
			ST_SKIP: begin
				if (take & i_in_last)
					next_state = ST_HDR;
			end
			default: next_state = ST_HDR;
		endcase
	end

	assign pl_start = is_tag ? `VFP_OFS_PAYLD_TAG : `VFP_OFS_PAYLD_UNTAG;
	assign et_sel   = is_tag ? etype_t : etype_u;
	assign vid_raw  = tci[`VFP_TCI_VID_HI:`VFP_TCI_VID_LO];

	always @* begin
		pl_end = len_q - `VFP_FCS_TRAIL;
	end

	// payload bytes pass unchanged; only the marker depends on the tag
	assign in_payload = (pos >= pl_start) & (pos <= pl_end);

	// ==========================================================
	// byte fifo on the data path, the last flag beside each byte
	vfp_fifo #(
		.WIDTH (`VFP_FIFO_WIDTH),
		.DEPTH (`VFP_FIFO_DEPTH),
		.AW    (`VFP_FIFO_AW)
	) u_fifo (
		.i_mclk      (i_mclk),
		.i_rst       (i_rst),
		.i_in_valid  (i_in_valid),
		.o_in_ready  (fifo_ready),
		.i_in_data   ({i_in_last, i_in_data}),
		.o_out_valid (o_out_valid),
		.i_out_ready (i_out_ready),
		.o_out_data  (fifo_out)
	);

	assign o_out_data = fifo_out[7:0];
	assign o_out_last = fifo_out[8];

	// payload marker travels in a parallel shift of fifo depth, tracked by its own occupancy count mk_cnt
	reg  [`VFP_FIFO_DEPTH-1:0] pl_mark;
	reg  [`VFP_FIFO_AW:0]      mk_cnt;
	wire                       mk_pop;
	assign mk_pop        = o_out_valid & i_out_ready;
	assign o_out_payload = pl_mark[0];

	// limitation: the header arrives before the payload marker is known for bytes 36 to 41, so
	// markers are computed with the tag decision only after byte 37; earlier bytes are never payload
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			pl_mark <= {`VFP_FIFO_DEPTH{1'b0}};
			mk_cnt  <= {(`VFP_FIFO_AW+1){1'b0}};
		end else begin
			case ({take, mk_pop})
				2'b10: begin
					pl_mark[mk_cnt[`VFP_FIFO_AW-1:0]] <= in_payload & (pos > `VFP_OFS_TPID_LO);
					mk_cnt <= mk_cnt + 1'b1;
				end
				2'b01: begin
					pl_mark <= {1'b0, pl_mark[`VFP_FIFO_DEPTH-1:1]};
					mk_cnt  <= mk_cnt - 1'b1;
				end
				2'b11: begin
					pl_mark <= {1'b0, pl_mark[`VFP_FIFO_DEPTH-1:1]};
					pl_mark[mk_cnt[`VFP_FIFO_AW-1:0] - 1'b1] <= in_payload & (pos > `VFP_OFS_TPID_LO);
				end
				default: ;
			endcase
		end
	end

	// ==========================================================
	// field results, published at the end of each record, except o_hdr_valid, which is set at byte 42
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_hdr_valid   <= 1'b0;
			o_tagged      <= 1'b0;
			o_prio_tag    <= 1'b0;
			o_pcp         <= `VFP_PCP_DEFAULT;
			o_dei         <= 1'b0;
			o_vid         <= `VFP_VID_DEFAULT;
			o_ethertype   <= 16'h0000;
			o_proto       <= `VFP_PROTO_OTHER;
			o_payload_len <= 16'h0000;
			o_len_short   <= 1'b0;
			o_len_long    <= 1'b0;
			o_frame_done  <= 1'b0;
		end else begin
			o_frame_done <= 1'b0;
			if (take & (pos == `VFP_OFS_PAYLD_TAG))
				o_hdr_valid <= 1'b1;
			if (take & i_in_last) begin
				o_frame_done <= 1'b1;
				o_tagged     <= is_tag;
				o_ethertype  <= et_sel;
				if (is_tag) begin
					o_pcp      <= tci[`VFP_TCI_PCP_HI:`VFP_TCI_PCP_LO];
					o_dei      <= tci[`VFP_TCI_DEI];
					o_prio_tag <= (vid_raw == `VFP_VID_NULL);
					o_vid      <= (vid_raw == `VFP_VID_NULL) ? `VFP_VID_DEFAULT : vid_raw;
				end else begin
					o_pcp      <= `VFP_PCP_DEFAULT;
					o_dei      <= 1'b0;
					o_prio_tag <= 1'b0;
					o_vid      <= `VFP_VID_DEFAULT;
				end
				case (et_sel)
					`VFP_ET_IPV4: o_proto <= `VFP_PROTO_IPV4;
					`VFP_ET_IPV6: o_proto <= `VFP_PROTO_IPV6;
					`VFP_ET_AVTP: o_proto <= `VFP_PROTO_AVTP;
					default:      o_proto <= `VFP_PROTO_OTHER;
				endcase
				if (pl_end >= pl_start) begin
					o_payload_len <= pl_end - pl_start + 16'h0001;
					o_len_short   <= (pl_end - pl_start + 16'h0001) < `VFP_PAYLD_MIN;
					o_len_long    <= (pl_end - pl_start + 16'h0001) > `VFP_PAYLD_MAX;
				end else begin
					o_payload_len <= 16'h0000;
					o_len_short   <= 1'b1;
					o_len_long    <= 1'b0;
				end
			end else if (take & (pos == 16'h0000)) begin
				o_hdr_valid <= 1'b0;
			end
		end
	end

endmodule

// >>> dv/vfp_chk_asserts.sv
// port assertions for the frame field parser
`timescale 1ns/1ps
module vfp_chk (
	input wire        i_mclk,
	input wire        i_rst,
	input wire        i_in_valid,
	input wire        o_in_ready,
	input wire        i_in_last,
	input wire        o_out_valid,
	input wire        o_tagged,
	input wire        o_prio_tag,
	input wire [2:0]  o_pcp,
	input wire        o_dei,
	input wire [11:0] o_vid,
	input wire [15:0] o_ethertype,
	input wire [1:0]  o_proto,
	input wire [15:0] o_payload_len,
	input wire        o_len_short,
	input wire        o_len_long,
	input wire        o_frame_done
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// ==========================================================
	// checks
	done_after_last_a: assert property (i_in_valid && o_in_ready && i_in_last |=> o_frame_done)
		else $error("no done after last byte");
	done_pulse_a: assert property (o_frame_done |=> !o_frame_done)
		else $error("done longer than one cycle");
	untag_dflt_a: assert property (o_frame_done && !o_tagged |-> o_pcp == 3'h0 && !o_dei && o_vid == 12'h001)
		else $error("untagged defaults wrong");
	null_vid_a: assert property (o_frame_done && o_prio_tag |-> o_tagged && o_vid == 12'h001)
		else $error("priority tag vid wrong");
	proto_map_a: assert property (o_frame_done |-> o_proto == (o_ethertype == 16'h0800 ? 2'h1 :
		o_ethertype == 16'h08DD ? 2'h2 : o_ethertype == 16'h22F0 ? 2'h3 : 2'h0))
		else $error("protocol class wrong");
	len_flags_a: assert property (o_frame_done |-> o_len_short == (o_payload_len < 16'h002E) &&
		o_len_long == (o_payload_len > 16'h05DC))
		else $error("length flags wrong");
	full_valid_a: assert property (!o_in_ready |-> o_out_valid)
		else $error("refusing while empty");
	field_hold_a: assert property (!o_frame_done |-> $stable(o_vid) && $stable(o_payload_len) && $stable(o_ethertype))
		else $error("fields moved between frames");
endmodule
bind vfp_parser vfp_chk i_vfp_chk (.i_mclk, .i_rst, .i_in_valid, .o_in_ready, .i_in_last, .o_out_valid,
	.o_tagged, .o_prio_tag, .o_pcp, .o_dei, .o_vid, .o_ethertype, .o_proto, .o_payload_len,
	.o_len_short, .o_len_long, .o_frame_done);

// >>> dv/vfp_host_model.sv
// host side frame queue model, drains bytes and tallies payload
`timescale 1ns/1ps
module vfp_host_model (
	input  wire        i_mclk,
	input  wire        i_clr,
	input  wire        i_stall,
	input  wire        i_valid,
	input  wire [7:0]  i_data,
	input  wire        i_payload,
	output reg         o_ready,
	output reg  [15:0] o_cnt,
	output reg  [15:0] o_pay,
	output reg  [15:0] o_bad
);
	initial o_ready = 1'b0;
	// stalling lets the fifo fill so the refusal path is reached
	always @(negedge i_mclk) o_ready <= !i_stall;
	always @(posedge i_mclk) begin
		if (i_clr) begin
			o_cnt <= 16'h0000;
			o_pay <= 16'h0000;
			o_bad <= 16'h0000;
		end else if (i_valid && o_ready) begin
			o_cnt <= o_cnt + 16'h0001;
			o_pay <= o_pay + {15'h0000, i_payload};
			if (i_payload && i_data !== o_cnt[7:0])
				o_bad <= o_bad + 16'h0001;
		end
	end
endmodule

// >>> dv/vfp_parser_tb_top.sv
// self-checking bench for the frame field parser
`timescale 1ns/1ps
module vfp_parser_tb_top;
	reg         i_mclk = 0, i_rst = 1, i_in_valid = 0, i_in_last = 0, stall = 1, clr = 0, saw_full = 0;
	reg  [7:0]  i_in_data = 8'h00;
	reg  [15:0] i_rec_len = 16'h0000;
	wire        o_in_ready, o_out_valid, i_out_ready, o_out_payload, o_hdr_valid, o_frame_done, o_out_last;
	reg  [15:0] last_at = 16'h0000;
	wire        o_tagged, o_prio_tag, o_dei, o_len_short, o_len_long;
	wire [2:0]  o_pcp;
	wire [1:0]  o_proto;
	wire [7:0]  o_out_data;
	wire [11:0] o_vid;
	wire [15:0] o_ethertype, o_payload_len, h_cnt, h_pay, h_bad;
	integer     err_count = 0, num_checks = 0, cyc = 0;
	vfp_parser i_vfp_parser (.i_mclk, .i_rst, .i_in_valid, .o_in_ready, .i_in_data, .i_in_last, .i_rec_len,
		.o_out_valid, .i_out_ready, .o_out_data, .o_out_last, .o_out_payload, .o_hdr_valid, .o_tagged,
		.o_prio_tag, .o_pcp, .o_dei, .o_vid, .o_ethertype, .o_proto, .o_payload_len, .o_len_short,
		.o_len_long, .o_frame_done);
	vfp_host_model i_vfp_host_model (.i_mclk, .i_clr(clr), .i_stall(stall), .i_valid(o_out_valid),
		.i_data(o_out_data), .i_payload(o_out_payload), .o_ready(i_out_ready), .o_cnt(h_cnt),
		.o_pay(h_pay), .o_bad(h_bad));
	initial forever #50 i_mclk = ~i_mclk;
	// bytes popped ahead of the one flagged last, so the flag must sit on the final byte
	always @(posedge i_mclk)
		if (o_out_valid && i_out_ready && o_out_last === 1'b1)
			last_at <= h_cnt;
	// ==========================================================
	// watchdog, sized well above the longest record
	always @(posedge i_mclk) begin
		cyc = cyc + 1;
		if (!o_in_ready)
			saw_full = 1;
		if (cyc == 6000) begin
			err_count = err_count + 1;
			finish_test;
		end
	end
	task finish_test;
		begin
			$display("checks %0d errors %0d", num_checks, err_count);
			if (err_count == 0 && num_checks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	task chk(input [15:0] seen, input [15:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("Error %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask
	// ==========================================================
	// record driver, header words most significant byte first
	task send(input [15:0] tpid, input [15:0] tci, input [15:0] et, input [15:0] len);
		integer n;
		reg [7:0] b;
		begin
			clr = 1;
			@(negedge i_mclk);
			clr = 0;
			for (n = 0; n < len; n = n + 1) begin
				b = n[7:0];
				if (n == 36 || n == 37)
					b = n == 36 ? tpid[15:8] : tpid[7:0];
				if (tpid == 16'h8100 && n > 37 && n < 42)
					b = n == 38 ? tci[15:8] : n == 39 ? tci[7:0] : n == 40 ? et[15:8] : et[7:0];
				@(negedge i_mclk);
				i_in_valid = 1;
				i_in_data = b;
				i_in_last = n == len - 1;
				i_rec_len = len;
				#1 while (o_in_ready !== 1'b1) @(negedge i_mclk) #1;
			end
			@(negedge i_mclk);
			i_in_valid = 0;
			i_in_last = 0;
			for (n = 0; n < 4 && o_frame_done !== 1'b1; n = n + 1) @(negedge i_mclk);
		end
	endtask
	task expect_rec(input [15:0] tpid, input [15:0] tci, input [15:0] et, input [15:0] len, input [1:0] pr);
		integer k;
		reg tg, nul;
		reg [15:0] pl;
		begin
			tg = tpid == 16'h8100;
			nul = tg && tci[11:0] == 12'h000;
			pl = len - (tg ? 16'h002E : 16'h002A);
			chk(o_frame_done, 1);
			chk(o_hdr_valid, 1);
			chk(o_tagged, tg);
			chk(o_prio_tag, nul);
			chk(o_pcp, tg ? tci[15:13] : 3'h0);
			chk(o_dei, tg & tci[12]);
			chk(o_vid, (!tg || nul) ? 12'h001 : tci[11:0]);
			chk(o_ethertype, et);
			chk(o_proto, pr);
			chk(o_payload_len, pl);
			chk(o_len_short, pl < 16'h002E);
			chk(o_len_long, pl > 16'h05DC);
			for (k = 0; k < 30 && o_out_valid !== 1'b0; k = k + 1) @(negedge i_mclk);
			@(negedge i_mclk);
			chk(h_cnt, len);
			chk(last_at, len - 16'h0001);
			chk(h_pay, pl);
			chk(h_bad, 0);
		end
	endtask
	// ==========================================================
	// scenarios
	task t_tag_min;
		begin
			send(16'h8100, 16'hB123, 16'h0800, 16'h005C);
			expect_rec(16'h8100, 16'hB123, 16'h0800, 16'h005C, 2'h1);
		end
	endtask
	task t_prio_short;
		begin
			send(16'h8100, 16'h6000, 16'h08DD, 16'h005B);
			expect_rec(16'h8100, 16'h6000, 16'h08DD, 16'h005B, 2'h2);
		end
	endtask
	task t_untag_stall;
		begin
			stall = 1;
			saw_full = 0;
			fork
				send(16'h22F0, 16'h0000, 16'h22F0, 16'h0064);
				begin
					repeat (20) @(negedge i_mclk);
					#1 stall = 0;
				end
			join
			expect_rec(16'h22F0, 16'h0000, 16'h22F0, 16'h0064, 2'h3);
			chk(saw_full, 1);
		end
	endtask
	task t_long;
		begin
			send(16'h8100, 16'h0FFF, 16'h1234, 16'h060B);
			expect_rec(16'h8100, 16'h0FFF, 16'h1234, 16'h060B, 2'h0);
		end
	endtask
	initial begin
		repeat (10) @(negedge i_mclk);
		chk(o_vid, 12'h001);
		chk(o_in_ready, 1);
		chk(o_out_valid, 0);
		#1 stall = 0;
		i_rst = 0;
		t_tag_min;
		t_prio_short;
		t_untag_stall;
		t_long;
		finish_test;
	end
endmodule
